// ---- verilog/acr_pkg.sv ----
package acr_pkg;

  // register map: printed offsets are word indices, byte address = 4 * index
  localparam int unsigned NUM_REGS         = 6;
  localparam logic [5:0]  IDX_CH1_OFF_HIGH = 6'h0f;
  localparam logic [5:0]  IDX_CH1_OFF_LOW  = 6'h10;
  localparam logic [5:0]  IDX_CH1_GAIN_HIGH = 6'h11;
  localparam logic [5:0]  IDX_CH1_GAIN_LOW = 6'h12;
  localparam logic [5:0]  IDX_CH2_SETUP    = 6'h13;
  localparam logic [5:0]  IDX_CH2_OFF_HIGH = 6'h14;
  localparam logic [5:0]  IDX_FIRST        = IDX_CH1_OFF_HIGH;
  localparam logic [5:0]  IDX_LAST         = IDX_CH2_OFF_HIGH;

  // reset values, ordered by index minus IDX_FIRST
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] RESET_TABLE [NUM_REGS] = '{
    RST_ZERO, RST_ZERO, RST_GAIN_HIGH, RST_ZERO, RST_ZERO, RST_ZERO};

  // writable bits per register; all others are reserved and read zero
  localparam logic [15:0] WMASK_FULL = 16'hffff;
  localparam logic [15:0] WMASK_LOW  = 16'hff00;
  localparam logic [15:0] WMASK_CFG  = 16'hffc7;
  localparam logic [15:0] WMASK_TABLE [NUM_REGS] = '{
    WMASK_FULL, WMASK_LOW, WMASK_FULL, WMASK_LOW, WMASK_CFG, WMASK_FULL};

  // channel setup word fields
  localparam int unsigned PHASE_MSB  = 15;
  localparam int unsigned PHASE_LSB  = 6;
  localparam int unsigned BYPASS_BIT = 2;
  localparam int unsigned SEL_MSB    = 1;
  localparam int unsigned SEL_LSB    = 0;

  // input selector codes and one-hot routes
  localparam logic [1:0] SEL_PINS     = 2'b00;
  localparam logic [1:0] SEL_SHORTED  = 2'b01;
  localparam logic [1:0] SEL_TEST_POS = 2'b10;
  localparam logic [1:0] SEL_TEST_NEG = 2'b11;
  localparam logic [3:0] ROUTE_RESET  = 4'h1;

  // phase delay: signed field plus this bias, plus one, gives modulator ticks to wait
  localparam logic [10:0] PHASE_BIAS = 11'h200;

endpackage

// ---- verilog/acr_phase_delay.sv ----
`timescale 1ns/1ps
// delays the channel sample strobe by a signed count of modulator ticks
module acr_phase_delay (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic [9:0] i_phase,
  input  wire logic       i_mod_tick,
  input  wire logic       i_ref_strobe,
  output logic            o_strobe
);

  logic [10:0] count_reg;
  logic        active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // phase delay count
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg  <= 11'h000;
      active_reg <= 1'b0;
      o_strobe   <= 1'b0;
    end else begin
      o_strobe <= 1'b0;
      if (i_ref_strobe) begin
        count_reg  <= acr_pkg::PHASE_BIAS + {i_phase[9], i_phase};
        active_reg <= 1'b1;
      end else if (active_reg && i_mod_tick) begin
        if (count_reg == 11'h000) begin
          active_reg <= 1'b0;
          o_strobe   <= 1'b1;
        end else begin
          count_reg <= count_reg - 11'h001;
        end
      end
    end
  end

  a_phase_fire: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    o_strobe |-> $past(active_reg && i_mod_tick && count_reg == 11'h000
                       && !i_ref_strobe))
    else $error("sample strobe fired before the delay ran out");

endmodule

// ---- verilog/acr_input_route.sv ----
`timescale 1ns/1ps
// decodes the channel input selector and the effective dc filter enable
module acr_input_route (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic [1:0] i_select,
  input  wire logic       i_bypass,
  input  wire logic       i_global_dc,
  output logic [3:0]      o_route,
  output logic            o_dc_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // selector to one-hot route
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_route <= acr_pkg::ROUTE_RESET;
    end else begin
      unique case (i_select)
        acr_pkg::SEL_PINS:     o_route <= 4'h1;
        acr_pkg::SEL_SHORTED:  o_route <= 4'h2;
        acr_pkg::SEL_TEST_POS: o_route <= 4'h4;
        acr_pkg::SEL_TEST_NEG: o_route <= 4'h8;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dc_enable <= 1'b0;
    end else begin
      o_dc_enable <= i_bypass ? 1'b0 : i_global_dc;
    end
  end

  a_route_onehot: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    ##1 o_route == (4'h1 << $past(i_select)))
    else $error("input route does not match selector");

  a_dc_bypass: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    $past(i_bypass) |-> !o_dc_enable)
    else $error("dc filter enabled while channel bypass set");

endmodule

// ---- verilog/acr_cal_regs.sv ----
`timescale 1ns/1ps
module acr_cal_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_global_dc_filter_setting,
  input  wire logic        i_mod_tick,
  input  wire logic        i_conv_ref_strobe,
  output logic [23:0]      o_ch1_offset_corr,
  output logic [23:0]      o_ch1_gain_corr,
  output logic [9:0]       o_ch2_phase_delay,
  output logic             o_ch2_dc_filter_bypass,
  output logic [1:0]       o_ch2_input_select,
  output logic [15:0]      o_ch2_offset_upper_bits,
  output logic             o_ch2_dc_filter_enable,
  output logic [3:0]       o_ch2_input_route,
  output logic             o_ch2_sample_strobe
);

  logic [15:0] regs_q [acr_pkg::NUM_REGS];
  logic [5:0]  idx;
  logic [5:0]  rel;
  logic        hit;
  logic        setup_phase;
  logic        access_fire;
  logic        wr_fire;
  logic [15:0] lane_mask;
  logic [15:0] rd_word;
  logic        written_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode: word index from byte address, aligned words only
  assign idx         = i_paddr[7:2];
  assign rel         = idx - acr_pkg::IDX_FIRST;
  assign hit         = (i_paddr[1:0] == 2'b00) && (idx >= acr_pkg::IDX_FIRST)
                       && (idx <= acr_pkg::IDX_LAST);
  assign setup_phase = i_psel && !i_penable;
  assign access_fire = i_psel && i_penable && o_pready;
  assign wr_fire     = access_fire && i_pwrite && hit;
  assign lane_mask   = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  // read mux over the register array
  always_comb begin
    rd_word = 16'h0000;
    if (hit) begin
      rd_word = regs_q[rel[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage, one entry per word
  genvar g;
  generate
    for (g = 0; g < acr_pkg::NUM_REGS; g = g + 1) begin : gen_reg
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          regs_q[g] <= acr_pkg::RESET_TABLE[g];
        end else if (wr_fire && rel == 6'(g)) begin
          regs_q[g] <= (regs_q[g] & ~(lane_mask & acr_pkg::WMASK_TABLE[g]))
                     | (i_pwdata[15:0] & lane_mask & acr_pkg::WMASK_TABLE[g]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access phase after every setup
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup_phase;
    end
  end

  // unmapped or unaligned address answers with an error
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= setup_phase && !hit;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_phase && !i_pwrite) begin
      o_prdata <= {16'h0000, rd_word};
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel 1 calibration words
  // signed offset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ch1_offset_corr <= {acr_pkg::RST_ZERO, acr_pkg::RST_ZERO[15:8]};
    end else begin
      o_ch1_offset_corr <= {regs_q[0], regs_q[1][15:8]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ch1_gain_corr <= {acr_pkg::RST_GAIN_HIGH, acr_pkg::RST_ZERO[15:8]};
    end else begin
      o_ch1_gain_corr <= {regs_q[2], regs_q[3][15:8]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel 2 setup fields and offset
  // setup fields
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ch2_phase_delay      <= 10'h000;
      o_ch2_dc_filter_bypass <= 1'b0;
      o_ch2_input_select     <= acr_pkg::SEL_PINS;
    end else begin
      o_ch2_phase_delay <=
        regs_q[4][acr_pkg::PHASE_MSB:acr_pkg::PHASE_LSB];
      o_ch2_dc_filter_bypass <= regs_q[4][acr_pkg::BYPASS_BIT];
      o_ch2_input_select <= regs_q[4][acr_pkg::SEL_MSB:acr_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ch2_offset_upper_bits <= acr_pkg::RST_ZERO;
    end else begin
      o_ch2_offset_upper_bits <= regs_q[5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing and filter control
  acr_input_route u_route (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_select    (o_ch2_input_select),
    .i_bypass    (o_ch2_dc_filter_bypass),
    .i_global_dc (i_global_dc_filter_setting),
    .o_route     (o_ch2_input_route),
    .o_dc_enable (o_ch2_dc_filter_enable)
  );

  acr_phase_delay u_phase (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_phase      (o_ch2_phase_delay),
    .i_mod_tick   (i_mod_tick),
    .i_ref_strobe (i_conv_ref_strobe),
    .o_strobe     (o_ch2_sample_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks: helper flag marks any accepted write to a mapped register since reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      written_reg <= 1'b0;
    end else if (wr_fire) begin
      written_reg <= 1'b1;
    end
  end

  a_off_high_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH1_OFF_HIGH && i_pstrb[1:0] == 2'b11
    |=> ##1 o_ch1_offset_corr[23:8] == $past(i_pwdata[15:0], 2))
    else $error("offset high word not mapped to bits 23:8");

  a_off_low_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH1_OFF_LOW && i_pstrb[1]
    |=> ##1 o_ch1_offset_corr[7:0] == $past(i_pwdata[15:8], 2))
    else $error("offset low byte not mapped to bits 7:0");

  a_low_rsvd_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    access_fire && !i_pwrite && (idx == acr_pkg::IDX_CH1_OFF_LOW
      || idx == acr_pkg::IDX_CH1_GAIN_LOW)
    |-> o_prdata[7:0] == 8'h00)
    else $error("reserved low byte read nonzero");

  a_gain_high_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH1_GAIN_HIGH && i_pstrb[1:0] == 2'b11
    |=> ##1 o_ch1_gain_corr[23:8] == $past(i_pwdata[15:0], 2))
    else $error("gain high word not mapped to bits 23:8");

  a_gain_low_rw: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH1_GAIN_LOW && i_pstrb[1]
    |=> ##1 o_ch1_gain_corr[7:0] == $past(i_pwdata[15:8], 2))
    else $error("gain low byte not written");

  a_gain_unity: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !written_reg |-> o_ch1_gain_corr == 24'h800000)
    else $error("gain not unity after reset");

  a_off_low_rst: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !written_reg |-> o_ch1_offset_corr[7:0] == 8'h00)
    else $error("offset low not zero after reset");

  a_gain_low_rst: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !written_reg |-> o_ch1_gain_corr[7:0] == 8'h00)
    else $error("gain low not zero after reset");

  a_setup_rsvd: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    access_fire && !i_pwrite && idx == acr_pkg::IDX_CH2_SETUP
    |-> o_prdata[5:3] == 3'b000)
    else $error("setup reserved bits read nonzero");

  a_setup_rst: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !written_reg |-> o_ch2_phase_delay == 10'h000
      && !o_ch2_dc_filter_bypass && o_ch2_input_select == 2'b00)
    else $error("setup fields not zero after reset");

  a_ch2_off_rst: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !written_reg |-> o_ch2_offset_upper_bits == 16'h0000)
    else $error("channel 2 offset not zero after reset");

  a_rsvd_ignored: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    access_fire && !i_pwrite |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read data bits nonzero");

  // checks: reserved storage, byte lanes, field mapping and refusals
  a_rsvd_kept: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    regs_q[1][7:0] == 8'h00 && regs_q[3][7:0] == 8'h00
      && regs_q[4][5:3] == 3'b000)
    else $error("reserved storage bits took a written value");

  a_lane_keep: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH1_OFF_HIGH && !i_pstrb[1]
    |=> regs_q[0][15:8] == $past(regs_q[0][15:8]))
    else $error("disabled byte lane changed the offset high word");

  a_ch2_off_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH2_OFF_HIGH && i_pstrb[1:0] == 2'b11
    |=> ##1 o_ch2_offset_upper_bits == $past(i_pwdata[15:0], 2))
    else $error("channel 2 offset word not copied to its output");

  a_setup_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH2_SETUP && i_pstrb[1:0] == 2'b11
    |=> ##1 o_ch2_phase_delay == $past(i_pwdata[15:6], 2)
      && o_ch2_input_select == $past(i_pwdata[1:0], 2))
    else $error("setup word not mapped to phase and selector");

  a_bypass_map: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    wr_fire && idx == acr_pkg::IDX_CH2_SETUP && i_pstrb[0]
    |=> ##1 o_ch2_dc_filter_bypass == $past(i_pwdata[2], 2))
    else $error("bypass bit not mapped to the channel output");

  a_read_back: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    access_fire && !i_pwrite && hit && idx == acr_pkg::IDX_CH1_OFF_HIGH
    |-> o_prdata[15:0] == o_ch1_offset_corr[23:8])
    else $error("offset high read back differs from the offset output");

  a_err_reply: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    access_fire && !hit
    |-> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("refused address did not answer with an error");

endmodule

// ---- test/acr_cal_regs_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); \
  end end
module acr_cal_regs_test;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wd;
    logic [3:0]  strb;
    logic [15:0] rd;
    logic        err;
  } acr_row_t;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        global_dc = 1'b0;
  logic        mod_tick = 1'b0;
  logic        ref_strobe = 1'b0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [23:0] o_off;
  logic [23:0] o_gain;
  logic [9:0]  o_phase;
  logic        o_bypass;
  logic [1:0]  o_sel;
  logic [15:0] o_ch2_off;
  logic        o_dc_en;
  logic [3:0]  o_route;
  logic        o_strobe;
  logic [31:0] rd;
  logic        er;
  logic        seen;
  int          n_errors = 0;
  int          n_compared = 0;
  int          hit;
  // rows: write, then read back; bad addresses must be refused
  localparam acr_row_t ROWS [10] = '{
    '{8'h3c, 16'hffff, 4'hf, 16'hffff, 1'b0},
    '{8'h40, 16'hffff, 4'hf, 16'hff00, 1'b0},
    '{8'h44, 16'h1234, 4'hf, 16'h1234, 1'b0},
    '{8'h48, 16'habcd, 4'hf, 16'hab00, 1'b0},
    '{8'h4c, 16'hffff, 4'hf, 16'hffc7, 1'b0},
    '{8'h50, 16'h5a5a, 4'hf, 16'h5a5a, 1'b0},
    '{8'h3c, 16'h0000, 4'h1, 16'hff00, 1'b0},
    '{8'h54, 16'hffff, 4'hf, 16'h0000, 1'b1},
    '{8'h3e, 16'hffff, 4'hf, 16'h0000, 1'b1},
    '{8'h38, 16'hffff, 4'hf, 16'h0000, 1'b1}
  };
  localparam logic [15:0] RST_VAL [6] = '{16'h0000, 16'h0000, 16'h8000,
    16'h0000, 16'h0000, 16'h0000};

  acr_cal_regs dut (
    .i_sys_clk                  (sys_clk),
    .i_reset_n                  (reset_n),
    .i_psel                     (psel),
    .i_penable                  (penable),
    .i_pwrite                   (pwrite),
    .i_paddr                    (paddr),
    .i_pwdata                   (pwdata),
    .i_pstrb                    (pstrb),
    .o_prdata                   (o_prdata),
    .o_pready                   (o_pready),
    .o_pslverr                  (o_pslverr),
    .i_global_dc_filter_setting (global_dc),
    .i_mod_tick                 (mod_tick),
    .i_conv_ref_strobe          (ref_strobe),
    .o_ch1_offset_corr          (o_off),
    .o_ch1_gain_corr            (o_gain),
    .o_ch2_phase_delay          (o_phase),
    .o_ch2_dc_filter_bypass     (o_bypass),
    .o_ch2_input_select         (o_sel),
    .o_ch2_offset_upper_bits    (o_ch2_off),
    .o_ch2_dc_filter_enable     (o_dc_en),
    .o_ch2_input_route          (o_route),
    .o_ch2_sample_strobe        (o_strobe)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and bus tasks
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n >= 16) n_errors++;
    rd = o_prdata;
    er = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // counts ticks until the delayed sample strobe shows
  task automatic phase_run(output int k);
    k = 0;
    @(posedge sys_clk) ref_strobe <= 1'b1;
    @(posedge sys_clk) ref_strobe <= 1'b0;
    for (int t = 1; t <= 6 && k == 0; t++) begin
      @(posedge sys_clk) mod_tick <= 1'b1;
      @(posedge sys_clk) mod_tick <= 1'b0;
      repeat (2) begin
        @(posedge sys_clk);
        if (o_strobe === 1'b1) k = t;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].addr, ROWS[i].wd, ROWS[i].strb);
      `CHK("wr err", ROWS[i].err, er)
      apb(1'b0, ROWS[i].addr, 16'h0000, 4'hf);
      `CHK("rd data", {16'h0000, ROWS[i].rd}, rd)
      `CHK("rd err", ROWS[i].err, er)
    end
    wr(8'h3c, 16'h8123);
    wr(8'h40, 16'h45ff);
    wr(8'h44, 16'hfedc);
    wr(8'h48, 16'hba00);
    repeat (3) @(posedge sys_clk);
    `CHK("offset", 24'h812345, o_off)
    `CHK("gain", 24'hfedcba, o_gain)
    // every selector code with bypass off and on; global is the inverse of select bit 0
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) global_dc <= ~i[0];
      wr(8'h4c, {10'h201, 3'b111, i[2], i[1:0]});
      repeat (3) @(posedge sys_clk);
      `CHK("select", i[1:0], o_sel)
      `CHK("route", 4'h1 << i[1:0], o_route)
      `CHK("bypass", i[2], o_bypass)
      `CHK("dc enable", i[2] ? 1'b0 : ~i[0], o_dc_en)
      `CHK("phase", 10'h201, o_phase)
    end
    // phase delay in ticks: -512 gives one tick, -509 four
    wr(8'h4c, 16'h8000);
    repeat (3) @(posedge sys_clk);
    phase_run(hit);
    `CHK("ticks min", 1, hit)
    wr(8'h4c, 16'h80c0);
    repeat (3) @(posedge sys_clk);
    phase_run(hit);
    `CHK("ticks", 4, hit)
    `CHK("ch2 offset", 16'h5a5a, o_ch2_off)
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("rst gain", 24'h800000, o_gain)
    `CHK("rst offset", 24'h000000, o_off)
    `CHK("rst pready", 1'b0, o_pready)
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'h3c + 8'(4 * i), 16'h0000, 4'hf);
      `CHK("rst value", {16'h0000, RST_VAL[i]}, rd)
    end
    end_of_test();
  end
endmodule
